// File: design/irqf_pkg.sv
// constants and types shared by the interrupt flag block
package irqf_pkg;

  localparam int unsigned NUM_SRC = 12;
  localparam int unsigned REG_W   = 4;
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned VEC_W   = 4;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_EN_TIMERS_SERIAL = 8'h2d;
  localparam logic [7:0] IDX_EN_PINS          = 8'h2f;
  localparam logic [7:0] IDX_EN_OTHER         = 8'h30;
  localparam logic [7:0] IDX_TIMER_ZERO_REQ   = 8'h39;
  localparam logic [7:0] IDX_PIN_THREE_REQ    = 8'h3b;
  localparam logic [7:0] IDX_EVENT_STATUS     = 8'h40;
  localparam logic [7:0] IDX_EVENT_MASK       = 8'h41;
  localparam logic [7:0] IDX_CORE_STATE       = 8'h42;

  // field positions
  localparam int unsigned PENDING_BIT   = 0;
  localparam int unsigned PIN_LEVEL_BIT = 3;
  localparam int unsigned EV_TIMER_ZERO = 0;
  localparam int unsigned EV_PIN_THREE  = 1;
  localparam int unsigned EV_ACCEPT     = 2;
  localparam int unsigned EN_OTHER_T0   = 0;
  localparam int unsigned EN_OTHER_P3   = 1;
  localparam int unsigned EN_OTHER_P4   = 2;
  localparam int unsigned EN_OTHER_T1   = 3;

  // reset values
  localparam logic [REG_W-1:0] RST_ENABLE  = 4'h0;
  localparam logic [REG_W-1:0] RST_REQUEST = 4'h0;
  localparam logic [REG_W-1:0] RST_EVENT   = 4'h0;

  // source index; vector address is index plus one
  localparam int unsigned SRC_SERIAL_THREE = 0;
  localparam int unsigned SRC_SERIAL_TWO   = 1;
  localparam int unsigned SRC_TIMER_THREE  = 2;
  localparam int unsigned SRC_TIMER_TWO    = 3;
  localparam int unsigned SRC_TIMER_ONE    = 4;
  localparam int unsigned SRC_TIMER_ZERO   = 5;
  localparam int unsigned SRC_PIN_FOUR     = 6;
  localparam int unsigned SRC_PIN_THREE    = 7;
  localparam int unsigned SRC_PIN_TWO      = 8;
  localparam int unsigned SRC_PIN_ONE      = 9;
  localparam int unsigned SRC_PIN_ZERO     = 10;
  localparam int unsigned SRC_CHIP_ENABLE  = 11;
  localparam logic [VEC_W-1:0] VEC_BASE    = 4'h1;

  typedef logic [NUM_SRC-1:0] irqf_src_t;

endpackage : irqf_pkg

// File: design/irqf_sel_if.sv
// candidate and chosen source between the flag logic and the selector
interface irqf_sel_if;
  irqf_pkg::irqf_src_t          cand;
  logic                         any;
  logic [irqf_pkg::VEC_W-1:0]   vector;
  irqf_pkg::irqf_src_t          onehot;

  modport flags (output cand, input any, input vector, input onehot);
  modport sel   (input cand, output any, output vector, output onehot);
endinterface : irqf_sel_if

// File: design/irqf_select.sv
// fixed priority selector: highest vector address wins
module irqf_select (
  // candidate sources and the choice
  irqf_sel_if.sel s
);

  always_comb begin
    s.any    = 1'b0;
    s.vector = '0;
    s.onehot = '0;
    for (int i = 0; i < irqf_pkg::NUM_SRC; i++) begin
      if (s.cand[i]) begin
        s.any    = 1'b1;
        s.vector = irqf_pkg::VEC_W'(i) + irqf_pkg::VEC_BASE;
        s.onehot = irqf_pkg::irqf_src_t'(1) << i;
      end
    end
  end

endmodule : irqf_select

// File: design/irqf_top.sv
// interrupt request and enable flags with apb register access
// Notes on behaviour
// - interrupt accepted only with enable flag, request flag and global enable all set
// - timer zero request register: pending flag in bit 0, upper bits read zero
// - pin three request register: pending flag in bit 0
// - pin three request register bit 3 shows present pin level
// - per-source enable flags sit in registers the core reads and writes
// - enable register 1 bit 0 gates timer two interrupt
// - enable register 1 bit 1 gates timer three interrupt
// - enable register 1 bit 2 gates serial two interrupt
// - enable register 1 bit 3 gates serial three interrupt
// - enable register 3 bit 0 gates chip enable pin interrupt
// - enable register 3 bit 1 gates pin zero interrupt
// - enable register 3 bit 2 gates pin one interrupt
// - enable register 3 bit 3 gates pin two interrupt
// - accepted interrupt branches to fixed vector, chip enable highest, serial three lowest
module irqf_top (
  // clock and reset
  pclk,
  presetn,
  // apb slave
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  // reset and clock-stop controls from the system
  watchdog_stack_reset,
  ce_reset,
  clock_stop,
  // core side
  global_irq_enable_instr,
  global_irq_disable_instr,
  irq_accept,
  irq_vector,
  // peripheral request events and levels
  timer_zero_event,
  pin_three_event,
  ext_pin_three,
  src_request,
  // event interrupt
  irq
);

  input  wire logic                          pclk;
  input  wire logic                          presetn;
  input  wire logic                          psel;
  input  wire logic                          penable;
  input  wire logic                          pwrite;
  input  wire logic [irqf_pkg::ADDR_W-1:0]   paddr;
  input  wire logic [31:0]                   pwdata;
  output var  logic [31:0]                   prdata;
  output var  logic                          pready;
  output var  logic                          pslverr;
  input  wire logic                          watchdog_stack_reset;
  input  wire logic                          ce_reset;
  input  wire logic                          clock_stop;
  input  wire logic                          global_irq_enable_instr;
  input  wire logic                          global_irq_disable_instr;
  output var  logic                          irq_accept;
  output var  logic [irqf_pkg::VEC_W-1:0]    irq_vector;
  input  wire logic                          timer_zero_event;
  input  wire logic                          pin_three_event;
  input  wire logic                          ext_pin_three;
  input  wire irqf_pkg::irqf_src_t           src_request;
  output var  logic                          irq;

  typedef struct packed {
    logic [irqf_pkg::REG_W-1:0] en_timers_serial;
    logic [irqf_pkg::REG_W-1:0] en_pins;
    logic [irqf_pkg::REG_W-1:0] en_other;
    logic                       timer_zero_pending;
    logic                       pin_three_pending;
    logic                       global_en;
    logic [irqf_pkg::REG_W-1:0] ev_status;
    logic [irqf_pkg::REG_W-1:0] ev_mask;
    logic [31:0]                rdata;
    logic                       ready;
    logic                       slverr;
    logic                       accept;
    logic [irqf_pkg::VEC_W-1:0] vector;
    logic                       irq;
  } irqf_state_t;

  irqf_state_t         st_q;
  irqf_state_t         st_d;
  irqf_sel_if          sel_if ();
  irqf_pkg::irqf_src_t enable_vec;
  irqf_pkg::irqf_src_t request_vec;
  logic [7:0]          index;
  logic                word_ok;
  logic                wr_en;
  logic                setup;
  logic [3:0]          wdat;
  logic [3:0]          rd_val;
  logic                rd_hit;

  irqf_select u_select (
    .s (sel_if.sel)
  );

  // byte address to register index; low two bits must be zero
  assign index   = paddr[9:2];
  assign word_ok = (paddr[1:0] == 2'b00) && (paddr[irqf_pkg::ADDR_W-1:10] == '0);
  assign setup   = psel && !penable;
  assign wr_en   = psel && penable && st_q.ready && pwrite && word_ok;
  assign wdat    = pwdata[3:0];

  // enable vector laid out by source index
  always_comb begin
    enable_vec = '0;
    enable_vec[irqf_pkg::SRC_TIMER_TWO]    = st_q.en_timers_serial[0];
    enable_vec[irqf_pkg::SRC_TIMER_THREE]  = st_q.en_timers_serial[1];
    enable_vec[irqf_pkg::SRC_SERIAL_TWO]   = st_q.en_timers_serial[2];
    enable_vec[irqf_pkg::SRC_SERIAL_THREE] = st_q.en_timers_serial[3];
    enable_vec[irqf_pkg::SRC_CHIP_ENABLE]  = st_q.en_pins[0];
    enable_vec[irqf_pkg::SRC_PIN_ZERO]     = st_q.en_pins[1];
    enable_vec[irqf_pkg::SRC_PIN_ONE]      = st_q.en_pins[2];
    enable_vec[irqf_pkg::SRC_PIN_TWO]      = st_q.en_pins[3];
    enable_vec[irqf_pkg::SRC_TIMER_ZERO]   = st_q.en_other[irqf_pkg::EN_OTHER_T0];
    enable_vec[irqf_pkg::SRC_PIN_THREE]    = st_q.en_other[irqf_pkg::EN_OTHER_P3];
    enable_vec[irqf_pkg::SRC_PIN_FOUR]     = st_q.en_other[irqf_pkg::EN_OTHER_P4];
    enable_vec[irqf_pkg::SRC_TIMER_ONE]    = st_q.en_other[irqf_pkg::EN_OTHER_T1];
  end

  // request flags held here replace the peripheral level for their sources
  always_comb begin
    request_vec = src_request;
    request_vec[irqf_pkg::SRC_TIMER_ZERO] = st_q.timer_zero_pending;
    request_vec[irqf_pkg::SRC_PIN_THREE]  = st_q.pin_three_pending;
  end

  // one candidate per source
  for (genvar g = 0; g < irqf_pkg::NUM_SRC; g++) begin : g_cand
    assign sel_if.cand[g] = enable_vec[g] && request_vec[g] && st_q.global_en;
  end

  // register read mux
  always_comb begin
    rd_val = '0;
    rd_hit = word_ok;
    unique case (index)
      irqf_pkg::IDX_EN_TIMERS_SERIAL: rd_val = st_q.en_timers_serial;
      irqf_pkg::IDX_EN_PINS:          rd_val = st_q.en_pins;
      irqf_pkg::IDX_EN_OTHER:         rd_val = st_q.en_other;
      irqf_pkg::IDX_TIMER_ZERO_REQ:   rd_val = {3'h0, st_q.timer_zero_pending};
      irqf_pkg::IDX_PIN_THREE_REQ:    rd_val = {ext_pin_three, 2'h0, st_q.pin_three_pending};
      irqf_pkg::IDX_EVENT_STATUS:     rd_val = st_q.ev_status;
      irqf_pkg::IDX_EVENT_MASK:       rd_val = st_q.ev_mask;
      irqf_pkg::IDX_CORE_STATE:       rd_val = {3'h0, st_q.global_en};
      default:                        rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    st_d = st_q;

    // apb answer: ready in the first access cycle, data captured at setup
    st_d.ready  = setup;
    if (setup) begin
      st_d.rdata  = {28'h0, rd_val};
      st_d.slverr = !rd_hit;
    end else if (!psel) begin
      st_d.rdata  = '0;
      st_d.slverr = 1'b0;
    end

    // register writes; unmapped ones are dropped
    if (wr_en) begin
      unique case (index)
        irqf_pkg::IDX_EN_TIMERS_SERIAL: st_d.en_timers_serial = wdat;
        irqf_pkg::IDX_EN_PINS:          st_d.en_pins = wdat;
        irqf_pkg::IDX_EN_OTHER:         st_d.en_other = wdat;
        irqf_pkg::IDX_TIMER_ZERO_REQ:   st_d.timer_zero_pending = wdat[irqf_pkg::PENDING_BIT];
        irqf_pkg::IDX_PIN_THREE_REQ:    st_d.pin_three_pending = wdat[irqf_pkg::PENDING_BIT];
        irqf_pkg::IDX_EVENT_STATUS:     st_d.ev_status = st_q.ev_status & ~wdat;
        irqf_pkg::IDX_EVENT_MASK:       st_d.ev_mask = wdat;
        irqf_pkg::IDX_CORE_STATE:       st_d.global_en = wdat[0];
        default:                        st_d.ev_mask = st_q.ev_mask;
      endcase
    end

    // acceptance: one pulse, global enable drops so nesting needs a fresh enable
    st_d.accept = 1'b0;
    // a held or resetting core takes nothing, so no flag is consumed unseen
    if (sel_if.any && !st_q.accept && !clock_stop && !ce_reset && !watchdog_stack_reset) begin
      st_d.accept    = 1'b1;
      st_d.vector    = sel_if.vector;
      st_d.global_en = 1'b0;
      if (sel_if.onehot[irqf_pkg::SRC_TIMER_ZERO]) begin
        st_d.timer_zero_pending = 1'b0;
      end
      if (sel_if.onehot[irqf_pkg::SRC_PIN_THREE]) begin
        st_d.pin_three_pending = 1'b0;
      end
      st_d.ev_status[irqf_pkg::EV_ACCEPT] = 1'b1;
    end

    // core instructions; enable wins over a same-cycle disable
    if (global_irq_disable_instr) begin
      st_d.global_en = 1'b0;
    end
    if (global_irq_enable_instr) begin
      st_d.global_en = 1'b1;
    end

    // hardware set wins over a clear in the same cycle
    if (timer_zero_event) begin
      st_d.timer_zero_pending = 1'b1;
      st_d.ev_status[irqf_pkg::EV_TIMER_ZERO] = 1'b1;
    end
    if (pin_three_event) begin
      st_d.pin_three_pending = 1'b1;
      st_d.ev_status[irqf_pkg::EV_PIN_THREE] = 1'b1;
    end

    // watchdog/stack reset clears flags; chip enable reset and clock stop keep them
    if (watchdog_stack_reset) begin
      st_d.en_timers_serial   = irqf_pkg::RST_ENABLE;
      st_d.en_pins            = irqf_pkg::RST_ENABLE;
      st_d.en_other           = irqf_pkg::RST_ENABLE;
      st_d.timer_zero_pending = irqf_pkg::RST_REQUEST[0];
      st_d.pin_three_pending  = irqf_pkg::RST_REQUEST[0];
      st_d.global_en          = 1'b0;
      st_d.accept             = 1'b0;
    end
    // clock stop freezes acceptance only; flags stay as they are
    if (clock_stop || ce_reset) begin
      st_d.accept = 1'b0;
    end

    st_d.irq = |(st_d.ev_status & st_d.ev_mask);
  end

  // power-on reset is the asynchronous reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{
        en_timers_serial:   irqf_pkg::RST_ENABLE,
        en_pins:            irqf_pkg::RST_ENABLE,
        en_other:           irqf_pkg::RST_ENABLE,
        timer_zero_pending: irqf_pkg::RST_REQUEST[0],
        pin_three_pending:  irqf_pkg::RST_REQUEST[0],
        global_en:          1'b0,
        ev_status:          irqf_pkg::RST_EVENT,
        ev_mask:            irqf_pkg::RST_EVENT,
        rdata:              32'h0000_0000,
        ready:              1'b0,
        slverr:             1'b0,
        accept:             1'b0,
        vector:             4'h0,
        irq:                1'b0
      };
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata     = st_q.rdata;
  assign pready     = st_q.ready;
  assign pslverr    = st_q.slverr;
  assign irq_accept = st_q.accept;
  assign irq_vector = st_q.vector;
  assign irq        = st_q.irq;

endmodule : irqf_top

// File: verif/irqf_properties.sv
// assertion checker for the interrupt flag block
module irqf_properties (
  // clock, reset and apb
  input wire logic                          pclk,
  input wire logic                          presetn,
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [irqf_pkg::ADDR_W-1:0]   paddr,
  input wire logic [31:0]                   prdata,
  input wire logic                          pready,
  input wire logic                          pslverr,
  // system, pin and core
  input wire logic                          ce_reset,
  input wire logic                          clock_stop,
  input wire logic                          ext_pin_three,
  input wire logic                          irq_accept,
  input wire logic [irqf_pkg::VEC_W-1:0]    irq_vector
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable) else $error("ready outside access");
  AST_UPPER_ZERO: assert property (pready |-> prdata[31:4] == 28'h0) else $error("upper bits set");
  AST_TZ_UPPER: assert property (pready && !pwrite && paddr == 12'he4 |-> prdata[3:1] == 3'h0)
    else $error("timer zero upper bits set");
  AST_PIN_LEVEL: assert property (pready && !pwrite && paddr == 12'hec |-> prdata[3] == $past(ext_pin_three))
    else $error("pin level wrong");
  AST_MISALIGNED_ERR: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr) else $error("no error");
  AST_ACCEPT_PULSE: assert property (irq_accept |=> !irq_accept) else $error("accept twice");
  AST_VECTOR_RANGE: assert property (irq_accept |-> irq_vector inside {[4'h1:4'hc]}) else $error("bad vector");
  AST_VECTOR_HOLD: assert property (!irq_accept |-> $stable(irq_vector)) else $error("vector moved");
  AST_HOLD_BLOCKS: assert property (ce_reset || clock_stop |=> !irq_accept) else $error("accept in hold");
endmodule : irqf_properties

bind irqf_top irqf_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .ce_reset, .clock_stop, .ext_pin_three, .irq_accept, .irq_vector);

// File: verif/irqf_periph_model.sv
// peripheral sources and pin level driving the request inputs
module irqf_periph_model (
  // clock
  input  wire logic                pclk,
  // requests toward the block
  output var  irqf_pkg::irqf_src_t src_request,
  output var  logic                timer_zero_event,
  output var  logic                pin_three_event,
  output var  logic                ext_pin_three
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    src_request = '0;
    timer_zero_event = 1'b0;
    pin_three_event = 1'b0;
    ext_pin_three = 1'b0;
  end
  // levels change only at an edge, like a real source
  task set_req(input irqf_pkg::irqf_src_t r, input logic lvl);
    src_request <= r;
    ext_pin_three <= lvl;
  endtask : set_req
  task fire(input logic pin);
    if (pin) pin_three_event <= 1'b1;
    else timer_zero_event <= 1'b1;
    @(posedge pclk);
    timer_zero_event <= 1'b0;
    pin_three_event <= 1'b0;
  endtask : fire
endmodule : irqf_periph_model

// File: verif/irqf_test.sv
// self-checking testbench for the interrupt flag block
`define CHK(g, x) begin comparisons++; if ((g) !== (x)) begin num_errors++; $display("[FAIL] %0t %h %h", $time, g, x); end end
module irqf_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_accept, irq;
  logic watchdog_stack_reset, ce_reset, clock_stop, global_irq_enable_instr, global_irq_disable_instr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] irq_vector, v;
  logic timer_zero_event, pin_three_event, ext_pin_three, e, got;
  irqf_pkg::irqf_src_t src_request;
  int num_errors, comparisons, src;
  irqf_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .watchdog_stack_reset, .ce_reset, .clock_stop, .global_irq_enable_instr, .global_irq_disable_instr,
    .irq_accept, .irq_vector, .timer_zero_event, .pin_three_event, .ext_pin_three, .src_request, .irq);
  irqf_periph_model model (.pclk, .src_request, .timer_zero_event, .pin_three_event, .ext_pin_three);
  task finish_test;
    if (num_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  // request held until pready is sampled high, bounded wait
  task apb(input logic w, input logic [11:0] a, input logic [3:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {28'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      finish_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task wr(input logic [7:0] idx, input logic [3:0] d);
    apb(1'b1, {2'h0, idx, 2'h0}, d);
  endtask : wr
  task rd(input logic [7:0] idx, input logic [3:0] x);
    apb(1'b0, {2'h0, idx, 2'h0}, 4'h0);
    `CHK(r, {28'h0, x})
  endtask : rd
  task ei;
    global_irq_enable_instr <= 1'b1;
    @(posedge pclk);
    global_irq_enable_instr <= 1'b0;
  endtask : ei
  task wait_acc(input int lim);
    got = 1'b0;
    for (int i = 0; i < lim && !got; i++) begin
      @(posedge pclk);
      got = (irq_accept === 1'b1);
    end
    v = irq_vector;
  endtask : wait_acc
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {watchdog_stack_reset, ce_reset, clock_stop, global_irq_enable_instr, global_irq_disable_instr} = '0;
    num_errors = 0;
    comparisons = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h2d, 4'h0);
    rd(8'h2f, 4'h0);
    rd(8'h39, 4'h0);
    model.set_req('0, 1'b1);
    rd(8'h3b, 4'h8);
    apb(1'b1, 12'h0b5, 4'hf);
    `CHK(e, 1'b1)
    rd(8'h2d, 4'h0);
    model.fire(1'b0);
    rd(8'h39, 4'h1);
    model.fire(1'b1);
    rd(8'h3b, 4'h9);
    for (int i = 0; i < 8; i++) begin
      src = (i < 4) ? 3 - i : 15 - i;
      model.set_req(12'h1 << src, 1'b1);
      ei();
      wait_acc(4);
      `CHK(got, 1'b0)
      wr((i < 4) ? 8'h2d : 8'h2f, 4'h1 << (i % 4));
      wait_acc(20);
      `CHK({got, v}, {1'b1, 4'(src + 1)})
      wr((i < 4) ? 8'h2d : 8'h2f, 4'h0);
    end
    model.set_req(12'h801, 1'b0);
    wr(8'h2d, 4'h8);
    wr(8'h2f, 4'h1);
    ei();
    wait_acc(20);
    `CHK({got, v}, 5'h1c)
    ce_reset <= 1'b1;
    clock_stop <= 1'b1;
    @(posedge pclk);
    ce_reset <= 1'b0;
    clock_stop <= 1'b0;
    rd(8'h2d, 4'h8);
    rd(8'h2f, 4'h1);
    watchdog_stack_reset <= 1'b1;
    @(posedge pclk);
    watchdog_stack_reset <= 1'b0;
    rd(8'h2d, 4'h0);
    rd(8'h2f, 4'h0);
    ei();
    global_irq_disable_instr <= 1'b1;
    @(posedge pclk);
    global_irq_disable_instr <= 1'b0;
    wr(8'h30, 4'h1);
    model.fire(1'b0);
    wait_acc(4);
    `CHK(got, 1'b0)
    ce_reset <= 1'b1;
    ei();
    wait_acc(4);
    `CHK(got, 1'b0)
    rd(8'h39, 4'h1);
    rd(8'h42, 4'h1);
    ce_reset <= 1'b0;
    wait_acc(20);
    `CHK({got, v}, 5'h16)
    rd(8'h39, 4'h0);
    rd(8'h42, 4'h0);
    wr(8'h40, 4'hf);
    model.fire(1'b0);
    rd(8'h40, 4'h1);
    wr(8'h41, 4'h1);
    @(posedge pclk);
    `CHK(irq, 1'b1)
    wr(8'h41, 4'h0);
    @(posedge pclk);
    `CHK(irq, 1'b0)
    wr(8'h41, 4'h1);
    wr(8'h40, 4'h1);
    @(posedge pclk);
    `CHK(irq, 1'b0)
    rd(8'h40, 4'h0);
    finish_test();
  end
endmodule : irqf_test
